/* File: logic/rrc_cmd_handler.sv */
/*
 * Remote register command handler: latches torque, limit, PID and
 * frequency words and runs the instruction queue. Assumes the link
 * logic delivers word writes and request bits on the same clock.
 */
`timescale 1ns/10ps

module rrc_cmd_handler
	import rrc_pkg::*;
(
	input wire logic clk_i,
	input wire logic sys_rst_i,
	input rrc_wr_t wr_i,
	input wire logic freq_write_request_a_i,
	input wire logic freq_write_request_b_i,
	input wire logic instruction_execute_request_i,
	input wire logic [SEL_W-1:0] application_selector_i,
	input wire logic [SEL_W-1:0] torque_source_selector_i,
	input wire logic [SEL_W-1:0] torque_limit_input_method_i,
	input wire logic [SEL_W-1:0] frequency_sign_selector_i,
	input wire logic [SEL_W-1:0] pid_action_selector_i,
	input wire logic [SEL_W-1:0] pid_setpoint_input_selector_i,
	input wire logic [SEL_W-1:0] pid_measured_input_selector_i,
	input wire logic instr_ready_i,
	output logic [15:0] stored_torque_value_a_o,
	output logic [15:0] stored_torque_value_b_o,
	output logic [15:0] torque_limit_o,
	output logic [15:0] pid_deviation_o,
	output logic [15:0] set_freq_mag_o,
	output logic dir_invert_o,
	output rrc_instr_t instr_o,
	output logic instr_valid_o,
	output logic instruction_complete_flag_o
);

	////////////////////////////////////////////////////////////////////////
	// Word shadows written by the master
	logic [15:0] freq_word_q, freq_word_d;
	logic [15:0] cmd_word_q, cmd_word_d;
	logic [15:0] lim_word_q, lim_word_d;
	logic [SLOT_N-1:0][15:0] codes_q, codes_d;
	logic [SLOT_N-1:0][15:0] wdata_q, wdata_d;
	logic [2:0] ext_slot;

	assign ext_slot = 3'(wr_i.idx[3:1]) + 3'h1;

	always_comb begin
		freq_word_d = freq_word_q;
		cmd_word_d = cmd_word_q;
		lim_word_d = lim_word_q;
		codes_d = codes_q;
		wdata_d = wdata_q;
		if (wr_i.we) begin
			case (wr_i.idx)
				IDX_SET_FREQ: begin
					freq_word_d = wr_i.data;
				end
				IDX_BASE_CODE: begin
					codes_d[SLOT_BASE] = wr_i.data;
				end
				IDX_BASE_DATA: begin
					wdata_d[SLOT_BASE] = wr_i.data;
				end
				IDX_PID_DEV: begin
					cmd_word_d = wr_i.data;
				end
				IDX_TQ_LIM: begin
					lim_word_d = wr_i.data;
				end
				default: begin
					if (wr_i.idx[4] && wr_i.idx[3:0] <= IDX_EXT_TOP) begin
						if (!wr_i.idx[0]) begin
							codes_d[ext_slot] = wr_i.data;
						end else begin
							wdata_d[ext_slot] = wr_i.data;
						end
					end
				end
			endcase
		end
	end

	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			freq_word_q <= RST_WORD;
			cmd_word_q <= RST_WORD;
			lim_word_q <= RST_WORD;
			codes_q <= {SLOT_N{RST_SLOT}};
			wdata_q <= {SLOT_N{RST_WORD}};
		end else begin
			freq_word_q <= freq_word_d;
			cmd_word_q <= cmd_word_d;
			lim_word_q <= lim_word_d;
			codes_q <= codes_d;
			wdata_q <= wdata_d;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Acceptance conditions
	logic fw_req_q;
	logic fw_req_d;
	logic fw_edge;
	logic tq_mode;
	logic lim_mode;
	logic cmd_in_range;
	logic lim_in_range;
	logic cmd_take;
	logic lim_take;
	logic pid_ok;
	logic pid_wr;
	logic pid_take;
	logic [15:0] cmd_max;

	assign fw_edge = (freq_write_request_a_i || freq_write_request_b_i)
		&& !fw_req_q;
	assign tq_mode = (application_selector_i == APP_TQ_A
		|| application_selector_i == APP_TQ_B
		|| application_selector_i == APP_TQ_C)
		&& (torque_source_selector_i == TQ_SRC_A
		|| torque_source_selector_i == TQ_SRC_B);
	assign lim_mode = tq_mode
		&& torque_limit_input_method_i == TQ_LIM_NET;
	assign cmd_max = (torque_source_selector_i == TQ_SRC_A) ?
		TQ_CMD_MAX_A : TQ_CMD_MAX_B;
	assign cmd_in_range = rrc_abs(cmd_word_q) <= cmd_max;
	assign lim_in_range = rrc_abs(lim_word_q) <= TQ_LIM_MAX;
	assign cmd_take = fw_edge && tq_mode && cmd_in_range;
	assign lim_take = fw_edge && lim_mode && lim_in_range;
	assign pid_ok = pid_action_selector_i != PID_OFF
		&& pid_setpoint_input_selector_i == PID_SRC_NET
		&& pid_measured_input_selector_i == PID_SRC_NET;
	assign pid_wr = wr_i.we && wr_i.idx == IDX_PID_DEV && !tq_mode;
	assign pid_take = pid_wr && pid_ok
		&& rrc_abs(wr_i.data) <= PID_DEV_MAX;

	////////////////////////////////////////////////////////////////////////
	// Stored values
	logic [15:0] tq_a_q, tq_a_d;
	logic [15:0] tq_b_q, tq_b_d;
	logic [15:0] lim_q, lim_d;
	logic [15:0] pid_q, pid_d;
	logic [15:0] fmag_q, fmag_d;
	logic finv_q, finv_d;

	always_comb begin
		tq_a_d = tq_a_q;
		tq_b_d = tq_b_q;
		lim_d = lim_q;
		pid_d = pid_q;
		fmag_d = fmag_q;
		finv_d = finv_q;
		fw_req_d = freq_write_request_a_i || freq_write_request_b_i;
		if (lim_take) begin
			lim_d = lim_word_q;
			tq_a_d = lim_word_q;
			tq_b_d = lim_word_q;
		end
		if (cmd_take) begin
			tq_a_d = cmd_word_q;
			tq_b_d = cmd_word_q;
		end
		if (pid_take) begin
			pid_d = wr_i.data;
		end
		if (fw_edge) begin
			if (frequency_sign_selector_i == FREQ_SIGNED
				&& freq_word_q[15]) begin
				fmag_d = rrc_abs(freq_word_q);
				finv_d = 1'b1;
			end else begin
				fmag_d = freq_word_q;
				finv_d = 1'b0;
			end
		end
	end

	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			fw_req_q <= 1'b0;
			tq_a_q <= RST_WORD;
			tq_b_q <= RST_WORD;
			lim_q <= RST_WORD;
			pid_q <= RST_WORD;
			fmag_q <= RST_WORD;
			finv_q <= 1'b0;
		end else begin
			fw_req_q <= fw_req_d;
			tq_a_q <= tq_a_d;
			tq_b_q <= tq_b_d;
			lim_q <= lim_d;
			pid_q <= pid_d;
			fmag_q <= fmag_d;
			finv_q <= finv_d;
		end
	end

	assign stored_torque_value_a_o = tq_a_q;
	assign stored_torque_value_b_o = tq_b_q;
	assign torque_limit_o = lim_q;
	assign pid_deviation_o = pid_q;
	assign set_freq_mag_o = fmag_q;
	assign dir_invert_o = finv_q;

	////////////////////////////////////////////////////////////////////////
	// Instruction queue
	rrc_instr_seq u_seq (
		.clk_i(clk_i),
		.sys_rst_i(sys_rst_i),
		.exec_req_i(instruction_execute_request_i),
		.codes_i(codes_q),
		.data_i(wdata_q),
		.ready_i(instr_ready_i),
		.instr_o(instr_o),
		.valid_o(instr_valid_o),
		.complete_o(instruction_complete_flag_o)
	);

	////////////////////////////////////////////////////////////////////////
	a_tq_accept: assert property (@(posedge clk_i) disable iff (sys_rst_i)
		cmd_take |=> (stored_torque_value_a_o == $past(cmd_word_q)
		&& stored_torque_value_b_o == $past(cmd_word_q)))
		else $error("torque command not taken");

	a_tq_mode_gate: assert property (@(posedge clk_i) disable iff (sys_rst_i)
		(fw_edge && !tq_mode) |=> ($stable(stored_torque_value_a_o)
		&& $stable(stored_torque_value_b_o)))
		else $error("torque taken outside torque mode");

	a_tq_range_keep: assert property (@(posedge clk_i) disable iff (sys_rst_i)
		(fw_edge && tq_mode && !cmd_in_range && !lim_take)
		|=> $stable(stored_torque_value_a_o))
		else $error("out of range torque stored");

	a_lim_take: assert property (@(posedge clk_i) disable iff (sys_rst_i)
		(lim_take && !cmd_take) |=> (torque_limit_o == $past(lim_word_q)
		&& stored_torque_value_b_o == $past(lim_word_q)))
		else $error("torque limit not taken");

	a_lim_gate: assert property (@(posedge clk_i) disable iff (sys_rst_i)
		(fw_edge && (!lim_mode || !lim_in_range))
		|=> $stable(torque_limit_o))
		else $error("torque limit taken when not allowed");

	a_pid_keep: assert property (@(posedge clk_i) disable iff (sys_rst_i)
		(pid_wr && (!pid_ok || rrc_abs(wr_i.data) > PID_DEV_MAX))
		|=> $stable(pid_deviation_o))
		else $error("PID word stored when not allowed");

	a_freq_sign: assert property (@(posedge clk_i) disable iff (sys_rst_i)
		(fw_edge && frequency_sign_selector_i == FREQ_SIGNED
		&& freq_word_q[15])
		|=> (dir_invert_o && set_freq_mag_o == rrc_abs($past(freq_word_q))))
		else $error("negative frequency not inverted");

	a_freq_unsigned: assert property (@(posedge clk_i) disable iff (sys_rst_i)
		(fw_edge && frequency_sign_selector_i != FREQ_SIGNED)
		|=> (!dir_invert_o && set_freq_mag_o == $past(freq_word_q)))
		else $error("unsigned frequency altered");

	a_freq_pos: assert property (@(posedge clk_i) disable iff (sys_rst_i)
		(fw_edge && frequency_sign_selector_i == FREQ_SIGNED
		&& !freq_word_q[15])
		|=> (!dir_invert_o && set_freq_mag_o == $past(freq_word_q)))
		else $error("positive frequency altered");

	a_lim_load: assert property (@(posedge clk_i) disable iff (sys_rst_i)
		lim_take |=> torque_limit_o == $past(lim_word_q))
		else $error("accepted torque limit not stored");

	a_pid_take: assert property (@(posedge clk_i) disable iff (sys_rst_i)
		pid_take |=> pid_deviation_o == $past(wr_i.data))
		else $error("accepted PID word not stored");

	a_pid_hold: assert property (@(posedge clk_i) disable iff (sys_rst_i)
		!pid_take |=> $stable(pid_deviation_o))
		else $error("PID word changed without a write");

	a_hold_idle: assert property (@(posedge clk_i) disable iff (sys_rst_i)
		!fw_edge |=> ($stable(stored_torque_value_a_o)
		&& $stable(torque_limit_o) && $stable(set_freq_mag_o)
		&& $stable(dir_invert_o)))
		else $error("torque or frequency changed without a request");

endmodule : rrc_cmd_handler

/* File: shared/rrc_pkg.sv */
/*
 * Constants, carrier types and helpers for the remote register command
 * handler. Assumes a single 10 MHz clock and same-clock link logic.
 */
package rrc_pkg;

	localparam int WORD_W = 16;
	localparam int SLOT_N = 6;
	localparam int SEL_W = 8;
	localparam logic [2:0] SLOT_BASE = 3'h0;
	localparam logic [2:0] SLOT_LAST = 3'h5;

	// Remote write word indices
	localparam logic [4:0] IDX_SET_FREQ = 5'h01;
	localparam logic [4:0] IDX_BASE_CODE = 5'h02;
	localparam logic [4:0] IDX_BASE_DATA = 5'h03;
	localparam logic [4:0] IDX_PID_DEV = 5'h0B;
	localparam logic [4:0] IDX_TQ_LIM = 5'h0C;
	localparam logic [3:0] IDX_EXT_TOP = 4'h9;

	// Selector values
	localparam logic [7:0] APP_TQ_A = 8'h0E;
	localparam logic [7:0] APP_TQ_B = 8'h12;
	localparam logic [7:0] APP_TQ_C = 8'h26;
	localparam logic [7:0] TQ_SRC_A = 8'h03;
	localparam logic [7:0] TQ_SRC_B = 8'h05;
	localparam logic [7:0] TQ_LIM_NET = 8'h02;
	localparam logic [7:0] FREQ_SIGNED = 8'h01;
	localparam logic [7:0] PID_OFF = 8'h00;
	localparam logic [7:0] PID_SRC_NET = 8'h00;

	// Ranges
	localparam logic [15:0] PID_DEV_MAX = 16'h2710;
	localparam logic [15:0] TQ_CMD_MAX_A = 16'h0FA0;
	localparam logic [15:0] TQ_CMD_MAX_B = 16'h0190;
	localparam logic [15:0] TQ_LIM_MAX = 16'h0FA0;
	localparam logic [15:0] SLOT_OFF = 16'hFFFF;

	// Values after reset
	localparam logic [15:0] RST_WORD = 16'h0000;
	localparam logic [15:0] RST_SLOT = 16'hFFFF;

	typedef struct packed {
		logic we;
		logic [4:0] idx;
		logic [15:0] data;
	} rrc_wr_t;

	typedef struct packed {
		logic [2:0] slot;
		logic [7:0] ext;
		logic [15:0] code;
		logic [15:0] data;
	} rrc_instr_t;

	typedef enum logic [1:0] {
		RRC_IDLE = 2'b00,
		RRC_SCAN = 2'b01,
		RRC_ISSUE = 2'b10,
		RRC_DONE = 2'b11
	} rrc_state_t;

	localparam rrc_instr_t RST_INSTR = '0;

	// Magnitude of a two's complement word
	function automatic logic [15:0] rrc_abs(input logic [15:0] v);
		rrc_abs = v[15] ? 16'(~v + 16'h0001) : v;
	endfunction : rrc_abs

endpackage : rrc_pkg

/* File: logic/rrc_instr_seq.sv */
/*
 * Instruction queue sequencer: walks the base slot and five extended
 * slots on each rising execute request seen while idle. Assumes same-clock inputs.
 */
`timescale 1ns/10ps
module rrc_instr_seq
	import rrc_pkg::*;
(
	input wire logic clk_i,
	input wire logic sys_rst_i,
	input wire logic exec_req_i,
	input wire logic [SLOT_N-1:0][15:0] codes_i,
	input wire logic [SLOT_N-1:0][15:0] data_i,
	input wire logic ready_i,
	output rrc_instr_t instr_o,
	output logic valid_o,
	output logic complete_o
);

	rrc_state_t state_q, state_d;
	logic [2:0] idx_q, idx_d;
	rrc_instr_t instr_q, instr_d;
	logic valid_q, valid_d;
	logic done_q, done_d;
	logic req_q;
	logic [15:0] code_sel, data_sel;

	assign code_sel = codes_i[idx_q];
	assign data_sel = data_i[idx_q];

	////////////////////////////////////////////////////////////////////////
	always_comb begin
		state_d = state_q;
		idx_d = idx_q;
		instr_d = instr_q;
		valid_d = valid_q;
		done_d = done_q;
		case (state_q)
			RRC_IDLE: begin
				if (exec_req_i && !req_q) begin
					state_d = RRC_SCAN;
					idx_d = SLOT_BASE;
					done_d = 1'b0;
				end
			end
			RRC_SCAN: begin
				if (idx_q != SLOT_BASE && code_sel == SLOT_OFF) begin
					if (idx_q == SLOT_LAST) begin
						state_d = RRC_DONE;
					end else begin
						idx_d = 3'(idx_q + 3'h1);
					end
				end else begin
					instr_d.slot = idx_q;
					if (idx_q == SLOT_BASE) begin
						instr_d.ext = 8'h00;
						instr_d.code = code_sel;
					end else begin
						instr_d.ext = code_sel[15:8];
						instr_d.code = {8'h00, code_sel[7:0]};
					end
					instr_d.data = data_sel;
					valid_d = 1'b1;
					state_d = RRC_ISSUE;
				end
			end
			RRC_ISSUE: begin
				if (ready_i) begin
					valid_d = 1'b0;
					if (idx_q == SLOT_LAST) begin
						state_d = RRC_DONE;
					end else begin
						idx_d = 3'(idx_q + 3'h1);
						state_d = RRC_SCAN;
					end
				end
			end
			RRC_DONE: begin
				done_d = 1'b1;
				state_d = RRC_IDLE;
			end
			default: begin
				state_d = RRC_IDLE;
			end
		endcase
	end

	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			state_q <= RRC_IDLE;
			idx_q <= SLOT_BASE;
			instr_q <= RST_INSTR;
			valid_q <= 1'b0;
			done_q <= 1'b0;
			req_q <= 1'b0;
		end else begin
			state_q <= state_d;
			idx_q <= idx_d;
			instr_q <= instr_d;
			valid_q <= valid_d;
			done_q <= done_d;
			req_q <= exec_req_i;
		end
	end

	assign instr_o = instr_q;
	assign valid_o = valid_q;
	assign complete_o = done_q;

	////////////////////////////////////////////////////////////////////////
	a_skip_off_slot: assert property (@(posedge clk_i) disable iff (sys_rst_i)
		(state_q == RRC_SCAN && idx_q != SLOT_BASE && code_sel == SLOT_OFF)
		|=> (!valid_q && (state_q == RRC_DONE
		|| idx_q == 3'($past(idx_q) + 3'h1))))
		else $error("disabled slot was issued");

	a_base_first: assert property (@(posedge clk_i) disable iff (sys_rst_i)
		(state_q == RRC_IDLE && exec_req_i && !req_q)
		|-> ##2 (valid_q && instr_q.slot == SLOT_BASE))
		else $error("base slot not issued first");

	a_order_up: assert property (@(posedge clk_i) disable iff (sys_rst_i)
		(state_q == RRC_ISSUE && ready_i && idx_q != SLOT_LAST)
		|=> (state_q == RRC_SCAN && idx_q == 3'($past(idx_q) + 3'h1)))
		else $error("slot order broken");

	a_done_after_last: assert property (@(posedge clk_i) disable iff (sys_rst_i)
		(state_q == RRC_ISSUE && ready_i && idx_q == SLOT_LAST)
		|-> ##2 complete_o)
		else $error("complete flag not raised");

	a_ext_pairing: assert property (@(posedge clk_i) disable iff (sys_rst_i)
		(state_q == RRC_SCAN && idx_q != SLOT_BASE && code_sel != SLOT_OFF)
		|=> (instr_q.ext == $past(code_sel[15:8])
		&& instr_q.data == $past(data_sel)))
		else $error("extended slot split or pairing wrong");

endmodule : rrc_instr_seq

/* File: verif/rrc_exec_model.sv */
/*
 * Instruction executor model: accepts the handler's instructions either
 * at once or after three waiting cycles.
 * Assumes the handler's clock and reset.
 */
`timescale 1ns/10ps
module rrc_exec_model
	import rrc_pkg::*;
(
	input wire logic clk_i,
	input wire logic sys_rst_i,
	input wire logic valid_i,
	input wire logic slow_i,
	output logic ready_o
);
	logic [1:0] wait_q;
	logic [1:0] wait_d;

	////////////////////////////////////////////////////////////////////////
	// Count waiting cycles while an instruction is offered
	always_comb begin
		wait_d = wait_q + 2'h1;
		if (!valid_i || ready_o) begin
			wait_d = 2'h0;
		end
	end

	always_ff @(posedge clk_i) begin
		wait_q <= sys_rst_i ? 2'h0 : wait_d;
	end

	assign ready_o = valid_i && (!slow_i || wait_q == 2'h3);
endmodule : rrc_exec_model

/* File: verif/rrc_cmd_handler_tb.sv */
/*
 * Bench: table of torque, limit and frequency cases, then PID words,
 * queue passes and a mid-run reset.
 * Assumes the executor model beside the handler.
 */
`timescale 1ns/10ps
module rrc_cmd_handler_tb
	import rrc_pkg::*;
;
	typedef struct packed {
		logic [7:0] app;
		logic [7:0] src;
		logic [7:0] mth;
		logic [15:0] cmd;
		logic [15:0] lim;
		logic [15:0] frq;
		logic [15:0] ea;
		logic [15:0] el;
		logic [15:0] em;
		logic ei;
	} rrc_row_t;
	logic clk_i = 1'h0;
	logic sys_rst_i = 1'h1;
	rrc_wr_t wr = '0;
	logic rq_a = 1'h0, rq_b = 1'h0, ex = 1'h0, slow = 1'h0;
	logic rdy, vld, cpl, inv;
	logic [7:0] app = 8'h00, src = 8'h00, mth = 8'h00, sgn = 8'h01;
	logic [7:0] pa = 8'h00, ps = 8'h00, pm = 8'h00;
	logic [15:0] sa, sb, lim, pid, mag;
	rrc_instr_t ins;
	rrc_instr_t log_q[$];
	rrc_instr_t exp_q[$];
	int errors = 0;
	int n_checks = 0;
	rrc_row_t rows[8] = '{
	'{8'h0E, 8'h03, 8'h02, 16'h0100, 16'h0200, 16'h0064,
		16'h0100, 16'h0200, 16'h0064, 1'h0},
	'{8'h12, 8'h05, 8'h02, 16'h0190, 16'hF060, 16'hFF9C,
		16'h0190, 16'hF060, 16'h0064, 1'h1},
	'{8'h26, 8'h05, 8'h02, 16'h0191, 16'h0FA1, 16'h8000,
		16'h0190, 16'hF060, 16'h8000, 1'h1},
	'{8'h26, 8'h03, 8'h01, 16'h0FA0, 16'h0010, 16'h7FFF,
		16'h0FA0, 16'hF060, 16'h7FFF, 1'h0},
	'{8'h0D, 8'h03, 8'h02, 16'h0005, 16'h0005, 16'h0001,
		16'h0FA0, 16'hF060, 16'h0001, 1'h0},
	'{8'h0E, 8'h04, 8'h02, 16'h0005, 16'h0005, 16'h0002,
		16'h0FA0, 16'hF060, 16'h0002, 1'h0},
	'{8'h0E, 8'h03, 8'h02, 16'hF060, 16'hF05F, 16'h0003,
		16'hF060, 16'hF060, 16'h0003, 1'h0},
	'{8'h0E, 8'h05, 8'h02, 16'h0191, 16'h0300, 16'h0004,
		16'h0300, 16'h0300, 16'h0004, 1'h0}};

	initial begin
		forever #50 clk_i = ~clk_i;
	end

	rrc_cmd_handler dut (
		.clk_i(clk_i), .sys_rst_i(sys_rst_i), .wr_i(wr),
		.freq_write_request_a_i(rq_a), .freq_write_request_b_i(rq_b),
		.instruction_execute_request_i(ex),
		.application_selector_i(app), .torque_source_selector_i(src),
		.torque_limit_input_method_i(mth), .frequency_sign_selector_i(sgn),
		.pid_action_selector_i(pa), .pid_setpoint_input_selector_i(ps),
		.pid_measured_input_selector_i(pm), .instr_ready_i(rdy),
		.stored_torque_value_a_o(sa), .stored_torque_value_b_o(sb),
		.torque_limit_o(lim), .pid_deviation_o(pid), .set_freq_mag_o(mag),
		.dir_invert_o(inv), .instr_o(ins), .instr_valid_o(vld),
		.instruction_complete_flag_o(cpl));

	rrc_exec_model exec (.clk_i(clk_i), .sys_rst_i(sys_rst_i),
		.valid_i(vld), .slow_i(slow), .ready_o(rdy));

	////////////////////////////////////////////////////////////////////////
	// Log every accepted instruction
	always @(posedge clk_i) begin
		if (vld === 1'h1 && rdy === 1'h1) begin
			log_q.push_back(ins);
		end
	end

	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		n_checks++;
		if (seen !== exp) begin
			errors++;
			$display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : check

	task automatic results();
		$display("checks=%0d errors=%0d", n_checks, errors);
		if (errors == 0 && n_checks > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask : results

	task automatic wr_word(input logic [4:0] idx, input logic [15:0] d);
		wr = '{we: 1'h1, idx: idx, data: d};
		@(negedge clk_i);
		wr = '0;
		@(negedge clk_i);
	endtask : wr_word

	task automatic take(input logic b);
		rq_a = !b;
		rq_b = b;
		repeat (2) @(negedge clk_i);
		rq_a = 1'h0;
		rq_b = 1'h0;
		@(negedge clk_i);
	endtask : take

	task automatic run_pass(input logic s);
		int k;
		slow = s;
		log_q.delete();
		ex = 1'h1;
		for (k = 0; k < 300 && (k < 3 || cpl !== 1'h1); k++) begin
			@(negedge clk_i);
			if (k == 2) check(16'(cpl), 16'h0000);
			ex = (k != 3);
		end
		if (k == 300) begin
			errors++;
			results();
		end
		ex = 1'h0;
		repeat (10) @(negedge clk_i);
		check(16'(cpl), 16'h0001);
		check(16'(log_q.size()), 16'(exp_q.size()));
		foreach (exp_q[i]) begin
			if (i < log_q.size()) begin
				check(16'(log_q[i].slot), 16'(exp_q[i].slot));
				check(16'(log_q[i].ext), 16'(exp_q[i].ext));
				check(log_q[i].code, exp_q[i].code);
				check(log_q[i].data, exp_q[i].data);
			end
		end
		exp_q.delete();
	endtask : run_pass

	initial begin
		repeat (16) @(negedge clk_i);
		sys_rst_i = 1'h0;
		@(negedge clk_i);
		foreach (rows[i]) begin
			app = rows[i].app;
			src = rows[i].src;
			mth = rows[i].mth;
			wr_word(IDX_PID_DEV, rows[i].cmd);
			wr_word(IDX_TQ_LIM, rows[i].lim);
			wr_word(IDX_SET_FREQ, rows[i].frq);
			take(i[0]);
			check(sa, rows[i].ea);
			check(sb, rows[i].ea);
			check(lim, rows[i].el);
			check(mag, rows[i].em);
			check(16'(inv), 16'(rows[i].ei));
		end
		// Unsigned frequency never inverts
		sgn = 8'h00;
		wr_word(IDX_SET_FREQ, 16'hFF9C);
		take(1'h0);
		check(16'(inv), 16'h0000);
		check(mag, 16'hFF9C);
		// PID deviation, scaled by one hundred, within range
		app = 8'h00;
		pa = 8'h01;
		wr_word(IDX_PID_DEV, 16'h2710);
		check(pid, 16'h2710);
		wr_word(IDX_PID_DEV, 16'hD8F0);
		check(pid, 16'hD8F0);
		wr_word(IDX_PID_DEV, 16'h2711);
		check(pid, 16'hD8F0);
		pa = 8'h00;
		wr_word(IDX_PID_DEV, 16'h0005);
		check(pid, 16'hD8F0);
		pa = 8'h01;
		ps = 8'h01;
		wr_word(IDX_PID_DEV, 16'h0005);
		check(pid, 16'hD8F0);
		// Codes and data loaded before execute, disabled where unused
		wr_word(IDX_BASE_CODE, 16'h0003);
		wr_word(IDX_BASE_DATA, 16'h1111);
		wr_word(5'h10, 16'h12AB);
		wr_word(5'h11, 16'h0000);
		wr_word(5'h12, 16'hFFFF);
		wr_word(5'h14, 16'h0034);
		wr_word(5'h15, 16'h2222);
		exp_q.push_back('{3'h0, 8'h00, 16'h0003, 16'h1111});
		exp_q.push_back('{3'h1, 8'h12, 16'h00AB, 16'h0000});
		exp_q.push_back('{3'h3, 8'h00, 16'h0034, 16'h2222});
		run_pass(1'h0);
		// Base slot runs even when disabled; slow executor
		wr_word(IDX_BASE_CODE, SLOT_OFF);
		wr_word(IDX_BASE_DATA, 16'h0000);
		wr_word(5'h10, SLOT_OFF);
		wr_word(5'h14, SLOT_OFF);
		wr_word(5'h18, 16'h5678);
		wr_word(5'h19, 16'h3333);
		exp_q.push_back('{3'h0, 8'h00, 16'hFFFF, 16'h0000});
		exp_q.push_back('{3'h5, 8'h56, 16'h0078, 16'h3333});
		run_pass(1'h1);
		// Mid-run reset clears every output
		sys_rst_i = 1'h1;
		repeat (2) @(negedge clk_i);
		check(sa | sb | lim | pid | mag, 16'h0000);
		check(16'({inv, vld, cpl}), 16'h0000);
		sys_rst_i = 1'h0;
		@(negedge clk_i);
		// Shadows come back as disabled codes and zero data
		exp_q.push_back('{3'h0, 8'h00, 16'hFFFF, 16'h0000});
		run_pass(1'h0);
		results();
	end
endmodule : rrc_cmd_handler_tb
